// [rtl/dcc_regs.svh]
// Register offsets, field positions, reset values and mode codes
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_OFS_CTRL      8'h00
`define DCC_OFS_FLAGS     8'h04
`define DCC_OFS_ENABLES   8'h08
`define DCC_OFS_INTCTL    8'h0c
`define DCC_OFS_PFDIR     8'h10
`define DCC_OFS_PFPORT    8'h14
`define DCC_BIT_TWO_RES   7
`define DCC_BIT_ONE_RES   6
`define DCC_BIT_TWO_INV   5
`define DCC_BIT_ONE_INV   4
`define DCC_BIT_SWITCH    3
`define DCC_BIT_CHG_FLAG  6
`define DCC_BIT_CHG_EN    6
`define DCC_BIT_GLOBAL    7
`define DCC_BIT_PERIPH    6
`define DCC_BIT_RF1       1
`define DCC_BIT_RF2       2
`define DCC_RST_CTRL_WR   6'h07
`define DCC_RST_BIT       1'b0
`define DCC_RST_PFDIR     8'hff
`define DCC_MODE_RESET    3'h0
`define DCC_MODE_OUT_A    3'h3
`define DCC_MODE_OUT_B    3'h5
`define DCC_MODE_FOUR_MUX 3'h6
`define DCC_MODE_OFF      3'h7
`define DCC_ANALOG_MASK   8'h78
`define DCC_NO_MASK       8'h00
`endif

// [rtl/dcc_pkg.sv]
// Types shared by the comparator control block
`default_nettype none
package dcc_pkg;
	typedef logic [2:0]  dcc_mode_t;
	typedef logic [7:0]  dcc_byte_t;
	typedef logic [31:0] dcc_word_t;
endpackage
`default_nettype wire

// [rtl/dcc_sync.sv]
// Two-flop synchroniser, one per input bit
`default_nettype none
module dcc_sync #(
	parameter int W = 10
) (
	// Clock, reset and enable
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] d_sync
);
	logic [W-1:0] stage;

	// First stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stage[i]  <= 1'b0;
				d_sync[i] <= 1'b0;
			end else if (ce) begin
				stage[i]  <= d_async[i];
				d_sync[i] <= stage[i];
			end
		end
	end
endmodule // dcc_sync
`default_nettype wire

// [rtl/dcc_top.sv]
// Dual comparator control, change flag and pin routing with APB registers
// Behaviour
// - Bit 7 shows comparator two result, plus above minus, flipped by inversion.
// - Bit 6 shows comparator one result, plus above minus, flipped by inversion.
// - Bit 5 inverts comparator two in register bit and on pin.
// - Bit 4 inverts comparator one everywhere it is seen.
// - Result bits are read-only, reset to zero, ignore writes.
// - In mode 110 bit 3 picks which pins feed the minus inputs.
// - Mode field bits 2..0 pick one of eight setups, reset to ones.
// - Internal reference goes to both plus inputs only in mode 110.
// - In pin-output modes results drive RF2 and RF1.
// - Direction bits still gate RF2 and RF1 drivers in those modes.
// - Port read returns zero on every analog comparator input pin except in mode 111.
// - Change flag bit 6 sets whenever either result changes.
// - Flag holds until software writes zero; writing one sets it.
// - Interrupt needs change, peripheral and global enables all set.
// - Any control register access ends the mismatch condition.
// - A lasting mismatch keeps setting the flag against clears.
// - A change landing on the access edge is absorbed, flag stays.
// - Mode 111 switches both comparators off.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "dcc_regs.svh"
`default_nettype none
module dcc_top (
	// Clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire dcc_pkg::dcc_word_t pwdata,
	output dcc_pkg::dcc_word_t     prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Analog side
	input  wire logic              cmp_one_raw,
	input  wire logic              cmp_two_raw,
	input  wire dcc_pkg::dcc_byte_t pf_pins,
	output logic                   cmp_one_on,
	output logic                   cmp_two_on,
	output logic                   vref_to_plus,
	output logic                   minus_switch,
	// Port pins RF2, RF1
	output logic                   rf2_out,
	output logic                   rf2_oe,
	output logic                   rf1_out,
	output logic                   rf1_oe,
	// Interrupt request
	output logic                   irq
);
	import dcc_pkg::*;

	logic [9:0] sync_q;
	logic       s_one;
	logic       s_two;
	dcc_byte_t  pf_s;
	logic [5:0] ctrl_wr;
	logic       one_res;
	logic       two_res;
	logic [1:0] last_res;
	logic       chg_flag;
	logic       chg_en;
	logic       global_irq_enable;
	logic       peripheral_irq_enable;
	dcc_byte_t  pf_dir;

	// Comparator decisions and port pins come from outside the clock
	dcc_sync #(.W(10)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d_async ({pf_pins, cmp_two_raw, cmp_one_raw}),
		.d_sync  (sync_q)
	);
	assign s_one = sync_q[0];
	assign s_two = sync_q[1];
	assign pf_s  = sync_q[9:2];

	// Mode decode
	dcc_mode_t mode;
	wire       active;
	wire       pin_mode;
	wire       four_mux;
	dcc_byte_t analog_mask;
	assign mode     = ctrl_wr[2:0];
	assign four_mux = (mode == `DCC_MODE_FOUR_MUX);
	// Reset mode and off mode both leave the comparators unpowered
	assign active   = (mode != `DCC_MODE_OFF) && (mode != `DCC_MODE_RESET);
	assign pin_mode = (mode == `DCC_MODE_OUT_A) || (mode == `DCC_MODE_OUT_B);
	assign analog_mask = (mode == `DCC_MODE_OFF) ? `DCC_NO_MASK : `DCC_ANALOG_MASK;

	// APB decode
	wire sel_ctrl;
	wire sel_flags;
	wire sel_en;
	wire sel_int;
	wire sel_dir;
	wire sel_port;
	wire hit;
	wire setup;
	wire done;
	wire wr;
	wire ctrl_acc;
	assign sel_ctrl  = (paddr == `DCC_OFS_CTRL);
	assign sel_flags = (paddr == `DCC_OFS_FLAGS);
	assign sel_en    = (paddr == `DCC_OFS_ENABLES);
	assign sel_int   = (paddr == `DCC_OFS_INTCTL);
	assign sel_dir   = (paddr == `DCC_OFS_PFDIR);
	assign sel_port  = (paddr == `DCC_OFS_PFPORT);
	assign hit       = sel_ctrl | sel_flags | sel_en | sel_int | sel_dir | sel_port;
	assign setup     = psel & ~penable;
	assign done      = psel & penable & pready;
	assign wr        = done & pwrite & hit;
	// Read or write of the control word both count as an access
	assign ctrl_acc  = done & sel_ctrl;

	// Read data mux, built in the setup cycle
	dcc_byte_t rd_byte;
	dcc_byte_t ctrl_view;
	assign ctrl_view = {two_res, one_res, ctrl_wr};
	assign rd_byte =
		sel_ctrl  ? ctrl_view :
		sel_flags ? (8'h00 | ({7'h00, chg_flag} << `DCC_BIT_CHG_FLAG)) :
		sel_en    ? (8'h00 | ({7'h00, chg_en} << `DCC_BIT_CHG_EN)) :
		sel_int   ? {global_irq_enable, peripheral_irq_enable, 6'h00} :
		sel_dir   ? pf_dir :
		sel_port  ? (pf_s & ~analog_mask) :
		8'h00;

	// Next result values
	wire next_one;
	wire next_two;
	assign next_one = active & (s_one ^ ctrl_wr[`DCC_BIT_ONE_INV]);
	assign next_two = active & (s_two ^ ctrl_wr[`DCC_BIT_TWO_INV]);

	// Mismatch against the value latched at the last control access
	wire mismatch;
	wire mism_set;
	wire next_flag;
	assign mismatch = ({two_res, one_res} != last_res);
	// An access edge absorbs a change, so that change sets nothing
	assign mism_set = mismatch & ~ctrl_acc;
	// Set wins over a software clear in the same cycle
	assign next_flag = (wr & sel_flags) ? (pwdata[`DCC_BIT_CHG_FLAG] | mism_set)
		: (chg_flag | mism_set);

	// APB response; one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= setup;
			pslverr <= setup & ~hit;
			if (setup)
				prdata <= {24'h00_0000, rd_byte};
		end
	end

	// Writable control bits; result bits have no write path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_wr <= `DCC_RST_CTRL_WR;
		else if (ce && wr && sel_ctrl)
			ctrl_wr <= pwdata[5:0];
	end

	// Result bits, reset to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			one_res <= `DCC_RST_BIT;
			two_res <= `DCC_RST_BIT;
		end else if (ce) begin
			one_res <= next_one;
			two_res <= next_two;
		end
	end

	// Latch of results taken on each control access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			last_res <= 2'h0;
		else if (ce && ctrl_acc)
			last_res <= {two_res, one_res};
	end

	// Change flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			chg_flag <= `DCC_RST_BIT;
		else if (ce)
			chg_flag <= next_flag;
	end

	// Enables and port direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_en <= `DCC_RST_BIT;
			global_irq_enable    <= `DCC_RST_BIT;
			peripheral_irq_enable   <= `DCC_RST_BIT;
			pf_dir <= `DCC_RST_PFDIR;
		end else if (ce && wr) begin
			if (sel_en)
				chg_en <= pwdata[`DCC_BIT_CHG_EN];
			if (sel_int) begin
				global_irq_enable  <= pwdata[`DCC_BIT_GLOBAL];
				peripheral_irq_enable <= pwdata[`DCC_BIT_PERIPH];
			end
			if (sel_dir)
				pf_dir <= pwdata[7:0];
		end
	end

	// Analog routing controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_one_on   <= 1'b0;
			cmp_two_on   <= 1'b0;
			vref_to_plus <= 1'b0;
			minus_switch <= 1'b0;
		end else if (ce) begin
			cmp_one_on   <= active;
			cmp_two_on   <= active;
			vref_to_plus <= four_mux;
			minus_switch <= four_mux & ctrl_wr[`DCC_BIT_SWITCH];
		end
	end

	// Pin drive; registered from the same next values as the result bits, so pins match them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rf2_out <= 1'b0;
			rf1_out <= 1'b0;
			rf2_oe  <= 1'b0;
			rf1_oe  <= 1'b0;
		end else if (ce) begin
			rf2_out <= next_two;
			rf1_out <= next_one;
			rf2_oe  <= pin_mode & ~pf_dir[`DCC_BIT_RF2];
			rf1_oe  <= pin_mode & ~pf_dir[`DCC_BIT_RF1];
		end
	end

	// Interrupt request; flag still sets while any enable is clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else if (ce)
			irq <= next_flag & chg_en & peripheral_irq_enable & global_irq_enable;
	end

	// Result follows the synchronised input with its inversion
	a_two_result_sense: assert property (@(posedge pclk) disable iff (!presetn)
		ce && active |=> two_res == $past(s_two ^ ctrl_wr[`DCC_BIT_TWO_INV]))
		else $error("comparator two result wrong");

	// Comparator one on the pin matches its register bit
	a_one_pin_match: assert property (@(posedge pclk) disable iff (!presetn)
		rf1_out == one_res)
		else $error("pin one differs from result bit");

	// Results read zero while the comparators are off
	a_off_results_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !active |=> !one_res && !two_res && !cmp_one_on)
		else $error("results not zero while off");

	// A control write loads the mode field
	a_mode_write_load: assert property (@(posedge pclk) disable iff (!presetn)
		ce && wr && sel_ctrl |=> mode == $past(pwdata[2:0]))
		else $error("mode field not written");

	// Reference routed only in the four-input mode
	a_vref_route_mode: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> vref_to_plus == ($past(mode) == `DCC_MODE_FOUR_MUX))
		else $error("reference routing wrong");

	// The RF2 driver stays off while its direction bit says input
	a_pin_dir_gate: assert property (@(posedge pclk) disable iff (!presetn)
		rf2_oe |-> !$past(pf_dir[`DCC_BIT_RF2]))
		else $error("pin driven while direction is input");

	// Analog pins read zero from the port register
	a_port_analog_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ce && setup && sel_port |=> (prdata[7:0] & $past(analog_mask)) == 8'h00)
		else $error("analog pin read nonzero");

	// Mismatch outside an access sets the flag
	a_flag_on_mismatch: assert property (@(posedge pclk) disable iff (!presetn)
		ce && mismatch && !ctrl_acc |=> chg_flag)
		else $error("flag not set on mismatch");

	// Request only with all three enables set
	a_irq_all_enables: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> $past(chg_en && peripheral_irq_enable && global_irq_enable))
		else $error("request without all enables");

	// Access ends the mismatch on the next cycle absent a new change
	a_access_ends_mism: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ctrl_acc |=> last_res == $past({two_res, one_res}))
		else $error("latch not refreshed on access");

	// Comparator one result follows its input with its inversion
	a_one_result_sense: assert property (@(posedge pclk) disable iff (!presetn)
		ce && active |=> one_res == $past(s_one ^ ctrl_wr[`DCC_BIT_ONE_INV]))
		else $error("comparator one result wrong");

	// Comparator two on the pin matches its register bit
	a_two_pin_match: assert property (@(posedge pclk) disable iff (!presetn)
		rf2_out == two_res)
		else $error("pin two differs from result bit");

	// Minus input swap only in the four-input mode with the switch set
	a_minus_switch_route: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> minus_switch == ($past(four_mux) && $past(ctrl_wr[`DCC_BIT_SWITCH])))
		else $error("minus input routing wrong");

	// No pin driver outside the pin-output modes
	a_pin_oe_mode: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !pin_mode |=> !rf1_oe && !rf2_oe)
		else $error("pin driven outside pin mode");

	// Flag holds unless software writes the flag register
	a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
		ce && chg_flag && !(wr && sel_flags) |=> chg_flag)
		else $error("flag dropped without a clear");

	// Software write of one sets the flag
	a_write_one_sets: assert property (@(posedge pclk) disable iff (!presetn)
		ce && wr && sel_flags && pwdata[`DCC_BIT_CHG_FLAG] |=> chg_flag)
		else $error("flag not set by software");

	// Request follows a set flag once all enables are on
	a_irq_when_enabled: assert property (@(posedge pclk) disable iff (!presetn)
		ce && chg_flag && chg_en && peripheral_irq_enable && global_irq_enable && !(wr && sel_flags) |=> irq)
		else $error("request missing with all enables");

	// A change seen at the access edge never sets a clear flag
	a_access_absorbs: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ctrl_acc && !chg_flag |=> !chg_flag)
		else $error("flag set by absorbed change");
endmodule // dcc_top
`default_nettype wire

// [rtl/dcc_placeholder_unused.sv]
// Empty; not used
`default_nettype none
`default_nettype wire

// [sim/dcc_analog_model.sv]
// Analog side model: comparator decisions from pin and reference levels
`default_nettype none
module dcc_analog_model (
	// Routing from the block
	input  wire logic       one_on,
	input  wire logic       two_on,
	input  wire logic       vref_sel,
	input  wire logic       sw_sel,
	// Analog levels
	input  wire logic [7:0] plus_one,
	input  wire logic [7:0] plus_two,
	input  wire logic [7:0] vref,
	input  wire logic [7:0] rf3,
	input  wire logic [7:0] rf4,
	input  wire logic [7:0] rf5,
	input  wire logic [7:0] rf6,
	// Decisions
	output logic            one_raw,
	output logic            two_raw
);
	timeunit 1ns;
	timeprecision 1ns;
	// Plus inputs take the internal reference when routed
	wire logic [7:0] p1 = vref_sel ? vref : plus_one;
	wire logic [7:0] p2 = vref_sel ? vref : plus_two;
	// Minus inputs swap only with the switch in mux mode
	wire logic [7:0] m1 = sw_sel ? rf5 : rf6;
	wire logic [7:0] m2 = sw_sel ? rf3 : rf4;
	// A powered-down comparator gives a useless level, here the wrong one
	assign one_raw = (p1 > m1) ^ ~one_on;
	assign two_raw = (p2 > m2) ^ ~two_on;
endmodule // dcc_analog_model
`default_nettype wire

// [sim/dcc_top_tb.sv]
// Register, pin and change flag tests of the comparator control block
`include "dcc_regs.svh"
`default_nettype none
module dcc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dcc_pkg::*;
	logic       pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	dcc_word_t  pwdata = 32'h0, prdata, rd;
	logic       pready, pslverr, err, cmp_one_raw, cmp_two_raw, cmp_one_on, cmp_two_on;
	logic       vref_to_plus, minus_switch, rf2_out, rf2_oe, rf1_out, rf1_oe, irq;
	dcc_byte_t  pf_pins = 8'h00;
	logic [7:0] lv1 = 0, lv2 = 0, vr = 0, r3 = 0, r4 = 0, r5 = 0, r6 = 0;
	int         failures = 0, check_count = 0, cyc = 0;
	always #50 pclk = ~pclk;
	// Block and its analog far side
	dcc_top i_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cmp_one_raw, .cmp_two_raw, .pf_pins, .cmp_one_on,
		.cmp_two_on, .vref_to_plus, .minus_switch, .rf2_out, .rf2_oe, .rf1_out, .rf1_oe, .irq);
	dcc_analog_model i_model (.one_on(cmp_one_on), .two_on(cmp_two_on), .vref_sel(vref_to_plus),
		.sw_sel(minus_switch), .plus_one(lv1), .plus_two(lv2), .vref(vr), .rf3(r3), .rf4(r4),
		.rf5(r5), .rf6(r6), .one_raw(cmp_one_raw), .two_raw(cmp_two_raw));
	// One APB transfer; waits for pready, takes data at that edge
	task automatic apb(input logic w, input logic [7:0] a, input dcc_byte_t d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			$display("wrong value at %0t: no pready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input dcc_byte_t d);
		apb(1'b1, a, d);
	endtask
	task automatic chk_reg(input logic [7:0] a, input dcc_word_t e, input logic ee);
		apb(1'b0, a, 8'h00);
		check_count++;
		if (rd !== e || err !== ee) begin
			failures++;
			$display("wrong value at %0t: reg %h read %h", $time, a, rd);
		end
	endtask
	task automatic chk_pin(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: pin level %b", $time, g);
		end
	endtask
	// Synchroniser plus result flop, flag one edge later
	task automatic settle;
		repeat (5) @(posedge pclk);
	endtask
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hang guard, far beyond the some two hundred cycles needed
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			give_verdict;
		end
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// Model outputs are wrong while off, so zero results show masking
		chk_reg(`DCC_OFS_CTRL, 32'h07, 1'b0);
		chk_reg(`DCC_OFS_PFDIR, 32'hff, 1'b0);
		wr(`DCC_OFS_CTRL, 8'hc7);
		chk_reg(`DCC_OFS_CTRL, 32'h07, 1'b0);
		chk_reg(8'h18, 32'h00, 1'b1);
		$display("test reset done");
		lv1 <= 8'd200;
		lv2 <= 8'd200;
		r6 <= 8'd100;
		r4 <= 8'd100;
		wr(`DCC_OFS_PFDIR, 8'hf9);
		wr(`DCC_OFS_CTRL, 8'h03);
		settle;
		chk_reg(`DCC_OFS_CTRL, 32'hc3, 1'b0);
		chk_pin(rf1_out, 1'b1);
		chk_pin(rf2_out, 1'b1);
		chk_pin(rf1_oe, 1'b1);
		chk_pin(rf2_oe, 1'b1);
		wr(`DCC_OFS_PFDIR, 8'hff);
		wr(`DCC_OFS_CTRL, 8'h35);
		settle;
		chk_pin(rf1_oe, 1'b0);
		chk_reg(`DCC_OFS_CTRL, 32'h35, 1'b0);
		chk_pin(rf1_out, 1'b0);
		chk_pin(rf2_out, 1'b0);
		$display("test polarity and pins done");
		// Every mode: power and reference routing
		for (int m = 0; m < 8; m++) begin
			wr(`DCC_OFS_CTRL, m[7:0]);
			settle;
			chk_pin(cmp_one_on, m != 0 && m != 7);
			chk_pin(cmp_two_on, m != 0 && m != 7);
			chk_pin(vref_to_plus, m == 6);
		end
		pf_pins <= 8'hff;
		wr(`DCC_OFS_CTRL, 8'h03);
		settle;
		chk_reg(`DCC_OFS_PFPORT, 32'h87, 1'b0);
		$display("test modes done");
		vr <= 8'd200;
		lv1 <= 8'd10;
		r5 <= 8'd100;
		r6 <= 8'd250;
		wr(`DCC_OFS_CTRL, 8'h0e);
		settle;
		chk_pin(minus_switch, 1'b1);
		chk_reg(`DCC_OFS_CTRL, 32'hce, 1'b0);
		wr(`DCC_OFS_CTRL, 8'h06);
		settle;
		chk_reg(`DCC_OFS_CTRL, 32'h86, 1'b0);
		$display("test input switch done");
		wr(`DCC_OFS_ENABLES, 8'h40);
		wr(`DCC_OFS_INTCTL, 8'hc0);
		wr(`DCC_OFS_FLAGS, 8'h00);
		// Request drops at the write edge; look one edge later
		@(posedge pclk);
		chk_pin(irq, 1'b0);
		r6 <= 8'd0;
		settle;
		chk_reg(`DCC_OFS_FLAGS, 32'h40, 1'b0);
		chk_pin(irq, 1'b1);
		wr(`DCC_OFS_FLAGS, 8'h00);
		chk_reg(`DCC_OFS_FLAGS, 32'h40, 1'b0);
		chk_reg(`DCC_OFS_CTRL, 32'hc6, 1'b0);
		wr(`DCC_OFS_FLAGS, 8'h00);
		chk_reg(`DCC_OFS_FLAGS, 32'h00, 1'b0);
		wr(`DCC_OFS_FLAGS, 8'h40);
		chk_reg(`DCC_OFS_FLAGS, 32'h40, 1'b0);
		wr(`DCC_OFS_INTCTL, 8'h80);
		settle;
		chk_pin(irq, 1'b0);
		chk_reg(`DCC_OFS_FLAGS, 32'h40, 1'b0);
		$display("test change flag done");
		give_verdict;
	end
endmodule // dcc_top_tb
`default_nettype wire
